/* logic/channel_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module channel_unit
(
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic msb_i,
  input  wire logic msa_i,
  input  wire logic elsb_i,
  input  wire logic elsa_i,
  input  wire logic rise_i,
  input  wire logic fall_i,
  input  wire logic match_i,
  input  wire logic gp_dir_i,
  input  wire logic gp_out_i,
  output logic      capture_o,
  output logic      pin_oe_o,
  output logic      pin_do_o
);
  logic conn;
  logic out_mode;
  logic level_q;

  assign conn     = elsb_i | elsa_i;
  assign out_mode = msb_i | msa_i;
  assign capture_o = conn & ~out_mode & ((elsa_i & rise_i) | (elsb_i & fall_i));

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      level_q <= 1'b1;
    else if (!conn)
      level_q <= ~msa_i;
    else if (out_mode && match_i)
    begin
      unique case ({elsb_i, elsa_i})
        2'b01: level_q <= ~level_q;
        2'b10: level_q <= 1'b0;
        default: level_q <= 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      pin_oe_o <= 1'b0;
      pin_do_o <= 1'b0;
    end
    else
    begin
      pin_oe_o <= conn ? out_mode : gp_dir_i;
      pin_do_o <= (conn && out_mode) ? level_q : gp_out_i;
    end
  end

  property p_preset;
    @(posedge clock_i) disable iff (sys_rst_i)
    !conn |=> level_q == !$past(msa_i);
  endproperty
  a_preset: assert property (p_preset) else $error("preset level wrong");

  property p_toggle;
    @(posedge clock_i) disable iff (sys_rst_i)
    (conn && out_mode && match_i && !elsb_i) |=> level_q != $past(level_q);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle on compare missed");

  property p_clear;
    @(posedge clock_i) disable iff (sys_rst_i)
    (conn && msb_i && match_i && elsb_i && !elsa_i) |=> !level_q ##1 pin_do_o == 1'b0;
  endproperty
  a_clear: assert property (p_clear) else $error("clear on compare missed");
endmodule : channel_unit
`default_nettype wire

/* logic/pin_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_edge_sync
(
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;
endmodule : pin_edge_sync
`default_nettype wire

/* logic/timer_channel_top.sv */
// Summary of operation
// - During debug break the counter holds its value.
// - With break clear enabled, status clears in break stick afterwards.
// - With break clear disabled (default), accesses in break leave status unchanged.
// - Armed two-step clear stays frozen in protected break, completes afterwards.
// - Prescaler select all ones counts rising edges of the external clock pin.
// - Clock pin is forced to input while selected as count clock.
// - Clock pin is a plain port pin when not selected.
// - Channels configure independently; only channel zero allows buffered modes.
// - Edge/level 00: mode bit A one gives low, zero high level.
// - Reset clears mode bit A and both edge/level bits.
// - Edge/level 00 disconnects channel, pin follows port control.
// - Capture modes: 01 rising, 10 falling, 11 either edge.
// - Unbuffered compare: 01 toggle, 10 clear, 11 set.
// - Buffered compare: 01 toggle, 10 clear, 11 set regardless of A.
`timescale 1ns/1ps
`default_nettype none
module timer_channel_top
  import timer_pkg::*;
(
  input  wire logic                      clock_i,
  input  wire logic                      sys_rst_i,
  input  wire logic [timer_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [timer_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                      we_i,
  input  wire logic                      re_i,
  output logic      [timer_pkg::DATA_W-1:0] rdata_o,
  input  wire logic                      break_i,
  input  wire logic                      count_clock_pin_i,
  input  wire logic                      port_e_bit0_direction_i,
  input  wire logic                      port_e_bit0_out_i,
  output logic                           count_clock_pin_oe_o,
  output logic                           count_clock_pin_do_o,
  input  wire logic [1:0]                ch_pin_i,
  input  wire logic [1:0]                ch_dir_i,
  input  wire logic [1:0]                ch_out_i,
  output logic      [1:0]                ch_pin_oe_o,
  output logic      [1:0]                ch_pin_do_o,
  output logic                           irq_o
);
  import timer_pkg::*;

  function automatic logic [PRE_W-1:0] ps_mask(input logic [2:0] ps);
    ps_mask = PRE_W'((8'h01 << ps) - 8'h01);
  endfunction : ps_mask

  function automatic logic flag_next(input logic flag, input logic set, input logic clr);
    flag_next = set | (flag & ~clr);
  endfunction : flag_next

  logic [2:0]       ps_q;
  logic             stop_q;
  logic             bce_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] mod_q;
  logic [PRE_W-1:0] pre_q;
  logic [1:0]       msb_q;
  logic [1:0]       msa_q;
  logic [1:0]       elsb_q;
  logic [1:0]       elsa_q;
  logic [CNT_W-1:0] val_q [2];
  logic [NFLAG-1:0] flag_q;
  logic [NFLAG-1:0] arm_q;
  logic [NFLAG-1:0] irq_st_q;
  logic [NFLAG-1:0] irq_mask_q;

  logic             allow;
  logic             ext_sel;
  logic             ext_rise;
  logic             run;
  logic             tick;
  logic             crst;
  logic             rd_irq;
  logic [1:0]       match;
  logic [1:0]       cap;
  logic [1:0]       rise;
  logic [1:0]       fall;
  logic [NFLAG-1:0] ev;
  logic [NFLAG-1:0] rd_sel;
  logic [NFLAG-1:0] wr_sel;
  logic [NFLAG-1:0] clr;

  assign allow   = !break_i || bce_q;
  assign ext_sel = (ps_q == PS_EXT);
  assign run     = !stop_q && !break_i;
  assign tick    = run && (ext_sel ? ext_rise : ((pre_q & ps_mask(ps_q)) == ps_mask(ps_q)));
  assign crst    = we_i && (addr_i == OFF_SC) && wdata_i[CRST_BIT];
  assign rd_irq  = re_i && (addr_i == OFF_IRQ_ST);

  assign rd_sel = {re_i && addr_i == OFF_CC1, re_i && addr_i == OFF_CC0, re_i && addr_i == OFF_SC};
  assign wr_sel = {we_i && addr_i == OFF_CC1, we_i && addr_i == OFF_CC0, we_i && addr_i == OFF_SC};
  assign clr    = wr_sel & arm_q & {NFLAG{allow && !wdata_i[FLAG_BIT]}};

  assign ev[IRQ_OVF] = tick && (cnt_q == mod_q);
  assign ev[IRQ_CH0] = cap[0] || (match[0] && (msb_q[0] || msa_q[0]));
  assign ev[IRQ_CH1] = cap[1] || (match[1] && (msb_q[1] || msa_q[1]));

  pin_edge_sync u_clk_sync
  (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .pin_i     (count_clock_pin_i),
    .rise_o    (ext_rise),
    .fall_o    ()
  );

  for (genvar g = 0; g < 2; g++)
  begin : g_ch
    assign match[g] = tick && (cnt_q == val_q[g]);

    pin_edge_sync u_sync
    (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (ch_pin_i[g]),
      .rise_o    (rise[g]),
      .fall_o    (fall[g])
    );

    channel_unit u_chan
    (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .msb_i     (msb_q[g]),
      .msa_i     (msa_q[g]),
      .elsb_i    (elsb_q[g]),
      .elsa_i    (elsa_q[g]),
      .rise_i    (rise[g]),
      .fall_i    (fall[g]),
      .match_i   (match[g]),
      .gp_dir_i  (ch_dir_i[g]),
      .gp_out_i  (ch_out_i[g]),
      .capture_o (cap[g]),
      .pin_oe_o  (ch_pin_oe_o[g]),
      .pin_do_o  (ch_pin_do_o[g])
    );
  end

  // control and configuration registers
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      ps_q       <= PS_RESET;
      stop_q     <= STOP_RESET;
      bce_q      <= 1'b0;
      mod_q      <= MOD_RESET;
      msb_q      <= 2'h0;
      msa_q      <= 2'h0;
      elsb_q     <= 2'h0;
      elsa_q     <= 2'h0;
      irq_mask_q <= MASK_RESET;
    end
    else if (we_i)
    begin
      unique case (addr_i)
        OFF_SC:
        begin
          stop_q <= wdata_i[STOP_BIT];
          ps_q   <= wdata_i[PS_LSB+:3];
        end
        OFF_MOD_HI: mod_q[15:8] <= wdata_i;
        OFF_MOD_LO: mod_q[7:0]  <= wdata_i;
        OFF_CC0:
        begin
          msb_q[0]  <= wdata_i[MSB_BIT];
          msa_q[0]  <= wdata_i[MSA_BIT];
          elsb_q[0] <= wdata_i[ELSB_BIT];
          elsa_q[0] <= wdata_i[ELSA_BIT];
        end
        OFF_CC1:
        begin
          msa_q[1]  <= wdata_i[MSA_BIT];
          elsb_q[1] <= wdata_i[ELSB_BIT];
          elsa_q[1] <= wdata_i[ELSA_BIT];
        end
        OFF_BREAK_FLAG_CONTROL_REG:    bce_q      <= wdata_i[BCE_BIT];
        OFF_IRQ_MSK: irq_mask_q <= wdata_i[NFLAG-1:0];
        default: ;
      endcase
    end
  end

  // prescaler and counter
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i || crst)
    begin
      pre_q <= '0;
      cnt_q <= CNT_RESET;
    end
    else
    begin
      if (run)
        pre_q <= pre_q + 7'h01;
      if (tick)
        cnt_q <= (cnt_q == mod_q) ? CNT_RESET : cnt_q + 16'h0001;
    end
  end

  // channel values: capture wins over a software write
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      val_q[0] <= CNT_RESET;
      val_q[1] <= CNT_RESET;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (cap[i])
          val_q[i] <= cnt_q;
        else if (we_i && addr_i == ((i == 0) ? OFF_VAL0_HI : OFF_VAL1_HI))
          val_q[i][15:8] <= wdata_i;
        else if (we_i && addr_i == ((i == 0) ? OFF_VAL0_LO : OFF_VAL1_LO))
          val_q[i][7:0] <= wdata_i;
      end
    end
  end

  // two-step flags: read while set arms, then a write of zero clears
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      flag_q <= '0;
      arm_q  <= '0;
    end
    else
    begin
      for (int k = 0; k < NFLAG; k++)
      begin
        flag_q[k] <= flag_next(flag_q[k], ev[k], clr[k]);
        if (allow && rd_sel[k] && flag_q[k])
          arm_q[k] <= 1'b1;
        else if (allow && wr_sel[k])
          arm_q[k] <= 1'b0;
      end
    end
  end

  // sticky interrupt status, cleared by reading it
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      irq_st_q <= '0;
      irq_o    <= 1'b0;
    end
    else
    begin
      for (int k = 0; k < NFLAG; k++)
        irq_st_q[k] <= flag_next(irq_st_q[k], ev[k], rd_irq && allow);
      irq_o <= |(irq_st_q & irq_mask_q);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      count_clock_pin_oe_o <= 1'b0;
      count_clock_pin_do_o <= 1'b0;
    end
    else
    begin
      count_clock_pin_oe_o <= !ext_sel && port_e_bit0_direction_i;
      count_clock_pin_do_o <= port_e_bit0_out_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
      rdata_o <= '0;
    else if (re_i)
    begin
      unique case (addr_i)
        OFF_SC:      rdata_o <= {flag_q[IRQ_OVF], 1'b0, stop_q, 2'b00, ps_q};
        OFF_CNT_HI:  rdata_o <= cnt_q[15:8];
        OFF_CNT_LO:  rdata_o <= cnt_q[7:0];
        OFF_MOD_HI:  rdata_o <= mod_q[15:8];
        OFF_MOD_LO:  rdata_o <= mod_q[7:0];
        OFF_CC0:     rdata_o <= {flag_q[IRQ_CH0], 1'b0, msb_q[0], msa_q[0], elsb_q[0], elsa_q[0], 2'b00};
        OFF_VAL0_HI: rdata_o <= val_q[0][15:8];
        OFF_VAL0_LO: rdata_o <= val_q[0][7:0];
        OFF_CC1:     rdata_o <= {flag_q[IRQ_CH1], 2'b00, msa_q[1], elsb_q[1], elsa_q[1], 2'b00};
        OFF_VAL1_HI: rdata_o <= val_q[1][15:8];
        OFF_VAL1_LO: rdata_o <= val_q[1][7:0];
        OFF_BREAK_FLAG_CONTROL_REG:    rdata_o <= {bce_q, 7'h00};
        OFF_IRQ_ST:  rdata_o <= {5'h00, irq_st_q};
        OFF_IRQ_MSK: rdata_o <= {5'h00, irq_mask_q};
        default:     rdata_o <= '0;
      endcase
    end
    else
      rdata_o <= '0;
  end

  property p_hold;
    @(posedge clock_i) disable iff (sys_rst_i)
    (break_i && !crst) |=> cnt_q == $past(cnt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved in break");

  property p_protect;
    @(posedge clock_i) disable iff (sys_rst_i)
    (break_i && !bce_q) |=> ((($past(flag_q) & ~flag_q) == '0) && (($past(irq_st_q) & ~irq_st_q) == '0));
  endproperty
  a_protect: assert property (p_protect) else $error("status changed in protected break");

  property p_rdclr;
    @(posedge clock_i) disable iff (sys_rst_i)
    (rd_irq && allow && ev == '0) |=> irq_st_q == '0 ##1 !irq_o;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("allowed read did not clear");

  property p_twostep;
    @(posedge clock_i) disable iff (sys_rst_i)
    (clr[IRQ_CH0] && !ev[IRQ_CH0]) |=> !flag_q[IRQ_CH0] && !arm_q[IRQ_CH0];
  endproperty
  a_twostep: assert property (p_twostep) else $error("second step did not clear");

  property p_ext;
    @(posedge clock_i) disable iff (sys_rst_i)
    (ext_sel && run && ext_rise && cnt_q != mod_q && !crst) |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_ext: assert property (p_ext) else $error("external edge not counted");

  property p_pin_in;
    @(posedge clock_i) disable iff (sys_rst_i)
    ext_sel |=> !count_clock_pin_oe_o;
  endproperty
  a_pin_in: assert property (p_pin_in) else $error("clock pin driven while selected");

  property p_gp;
    @(posedge clock_i) disable iff (sys_rst_i)
    !ext_sel |=> count_clock_pin_oe_o == $past(port_e_bit0_direction_i);
  endproperty
  a_gp: assert property (p_gp) else $error("clock pin not under port control");

  property p_disc;
    @(posedge clock_i) disable iff (sys_rst_i)
    (!elsb_q[1] && !elsa_q[1]) |=> ch_pin_oe_o[1] == $past(ch_dir_i[1]);
  endproperty
  a_disc: assert property (p_disc) else $error("disconnected channel drives pin");

  property p_nobuf;
    @(posedge clock_i) disable iff (sys_rst_i) msb_q[1] == 1'b0;
  endproperty
  a_nobuf: assert property (p_nobuf) else $error("channel one in buffered mode");

  property p_rst;
    @(posedge clock_i) sys_rst_i |=> (msa_q == 2'h0) && (elsb_q == 2'h0) && (elsa_q == 2'h0);
  endproperty
  a_rst: assert property (p_rst) else $error("reset left mode bits set");

  c_capture: cover property (@(posedge clock_i) disable iff (sys_rst_i) cap[0] ##1 flag_q[IRQ_CH0]);
  c_ext:     cover property (@(posedge clock_i) disable iff (sys_rst_i) ext_sel && tick);
  c_break:   cover property (@(posedge clock_i) disable iff (sys_rst_i) break_i && arm_q != '0 ##1 !break_i);
endmodule : timer_channel_top
`default_nettype wire

/* pkg/timer_pkg.sv */
package timer_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned PRE_W  = 7;
  localparam int unsigned NFLAG  = 3;

  localparam logic [ADDR_W-1:0] OFF_SC      = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_CNT_HI  = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_CNT_LO  = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_MOD_HI  = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_MOD_LO  = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_CC0     = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_VAL0_HI = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_VAL0_LO = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_CC1     = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_VAL1_HI = 4'h9;
  localparam logic [ADDR_W-1:0] OFF_VAL1_LO = 4'ha;
  localparam logic [ADDR_W-1:0] OFF_BREAK_FLAG_CONTROL_REG    = 4'hb;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ST  = 4'hc;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MSK = 4'hd;

  // flag bit sits at the same place in status/control and channel control
  localparam int unsigned FLAG_BIT  = 7;
  localparam int unsigned STOP_BIT  = 5;
  localparam int unsigned CRST_BIT  = 4;
  localparam int unsigned PS_LSB    = 0;
  localparam int unsigned MSB_BIT   = 5;
  localparam int unsigned MSA_BIT   = 4;
  localparam int unsigned ELSB_BIT  = 3;
  localparam int unsigned ELSA_BIT  = 2;
  localparam int unsigned BCE_BIT   = 7;

  localparam int unsigned IRQ_OVF   = 0;
  localparam int unsigned IRQ_CH0   = 1;
  localparam int unsigned IRQ_CH1   = 2;

  localparam logic [2:0]       PS_EXT      = 3'h7;
  localparam logic [2:0]       PS_RESET    = 3'h0;
  localparam logic             STOP_RESET  = 1'b1;
  localparam logic [CNT_W-1:0] MOD_RESET   = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_RESET   = 16'h0000;
  localparam logic [NFLAG-1:0] MASK_RESET  = 3'h0;
endpackage : timer_pkg

/* test/pin_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_partner
(
  input  wire logic       clock_i,
  input  wire logic       go_i,
  input  wire logic [3:0] half_i,
  input  wire logic [7:0] pulses_i,
  input  wire logic [1:0] ch_lvl_i,
  output logic            clk_pin_o,
  output logic [1:0]      ch_pin_o,
  output logic            busy_o
);
  // far side drives the channel lines whenever the block leaves them
  assign ch_pin_o = ch_lvl_i;

  // count clock idles low between bursts
  initial
  begin
    int h;
    clk_pin_o = 1'b0;
    busy_o    = 1'b0;
    forever
    begin
      @(posedge clock_i);
      if (go_i)
      begin
        // two bus cycles per phase at least: never faster than a quarter of the bus rate
        h = (half_i < 4'h2) ? 2 : int'(half_i);
        busy_o <= 1'b1;
        repeat (pulses_i)
        begin
          repeat (h) @(posedge clock_i);
          clk_pin_o <= 1'b1;
          repeat (h) @(posedge clock_i);
          clk_pin_o <= 1'b0;
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule : pin_partner
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import timer_pkg::*;
  logic              clock_i;
  logic              sys_rst_i;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic              we;
  logic              re;
  logic              brk;
  logic              pdir;
  logic              pout;
  logic              cpin_oe;
  logic              cpin_do;
  logic              pclk;
  logic [1:0]        chd;
  logic [1:0]        cho;
  logic [1:0]        ch_oe;
  logic [1:0]        ch_do;
  logic [1:0]        ch_lvl;
  logic [1:0]        p_ch;
  logic              irq;
  logic [3:0]        half;
  logic [7:0]        npul;
  logic              go;
  logic              busy;
  logic [7:0]        d;
  logic [7:0]        cfg;
  logic [1:0]        code;
  logic              ma;
  int                n;
  int                seed;
  int                mismatches;
  int                checks_done;
  wire logic         clk_wire = cpin_oe ? cpin_do : pclk;
  wire logic [1:0]   ch_wire;
  assign ch_wire[0] = ch_oe[0] ? ch_do[0] : p_ch[0];
  assign ch_wire[1] = ch_oe[1] ? ch_do[1] : p_ch[1];

  timer_channel_top i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata),
    .we_i(we), .re_i(re), .rdata_o(rdata), .break_i(brk), .count_clock_pin_i(clk_wire),
    .port_e_bit0_direction_i(pdir), .port_e_bit0_out_i(pout), .count_clock_pin_oe_o(cpin_oe),
    .count_clock_pin_do_o(cpin_do), .ch_pin_i(ch_wire), .ch_dir_i(chd), .ch_out_i(cho),
    .ch_pin_oe_o(ch_oe), .ch_pin_do_o(ch_do), .irq_o(irq));

  pin_partner i_partner (.clock_i(clock_i), .go_i(go), .half_i(half), .pulses_i(npul),
    .ch_lvl_i(ch_lvl), .clk_pin_o(pclk), .ch_pin_o(p_ch), .busy_o(busy));

  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  function automatic logic out_lvl(input logic pre, input logic [1:0] c);
    return (c == 2'h1) ? ~pre : c[0];
  endfunction : out_lvl

  function automatic logic cap_hit(input logic [1:0] c, input logic rising);
    return rising ? c[0] : c[1];
  endfunction : cap_hit

  // counter ticks in k bus cycles with prescaler select s
  function automatic int ticks(input int k, input int s);
    return k >> s;
  endfunction : ticks

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clock_i);
    addr  <= a;
    wdata <= v;
    we    <= 1'b1;
    @(posedge clock_i);
    we <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clock_i);
    addr <= a;
    re   <= 1'b1;
    @(posedge clock_i);
    re <= 1'b0;
    @(posedge clock_i);
    v = rdata;
  endtask : rd

  // run the counter from zero on the bus clock until one compare has passed
  task automatic fire();
    wr(OFF_SC, 8'h10);
    repeat (20) @(posedge clock_i);
    wr(OFF_SC, 8'h20);
  endtask : fire

  task automatic pulses(input logic [7:0] k);
    int w;
    npul <= k;
    go   <= 1'b1;
    @(posedge clock_i);
    go <= 1'b0;
    @(posedge clock_i);
    w = 0;
    while (busy && w < 500)
    begin
      @(posedge clock_i);
      w++;
    end
    chk(busy, 1'b0);
    repeat (8) @(posedge clock_i);
  endtask : pulses

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    end_of_test();
  end

  initial
  begin
    seed = 32'h0b8787ce;
    mismatches = 0;
    checks_done = 0;
    {sys_rst_i, addr, wdata, we, re, brk, pdir, pout, go} = {1'b1, 18'h0};
    {chd, cho, ch_lvl, half, npul} = 18'h0;
    repeat (12) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rd(OFF_SC, d);
    chk(d, 8'h20);
    rd(OFF_CC0, d);
    chk(d, 8'h00);
    rd(OFF_CC1, d);
    chk(d, 8'h00);
    rd(OFF_MOD_LO, d);
    chk(d, 8'hff);
    wr(4'he, 8'h5a);
    rd(4'he, d);
    chk(d, 8'h00);
    wr(OFF_CC1, 8'h3c);
    rd(OFF_CC1, d);
    chk(d, 8'h1c);
    wr(OFF_CC1, 8'h00);
    $display("test reset_map done");
    repeat (6)
    begin
      {pdir, pout, chd, cho} <= 6'($random(seed));
      repeat (3) @(posedge clock_i);
      chk({cpin_oe, cpin_do}, {pdir, pout});
      chk({ch_oe, ch_do}, {chd, cho});
    end
    chd <= 2'b00;
    $display("test port_pins done");
    wr(OFF_SC, 8'h37);
    pdir <= 1'b1;
    wr(OFF_SC, 8'h07);
    repeat (2) @(posedge clock_i);
    chk(cpin_oe, 1'b0);
    n = 1 + ($random(seed) & 7);
    half <= 4'(2 + ($random(seed) & 3));
    pulses(8'(n));
    rd(OFF_CNT_LO, d);
    chk(d, 8'(n));
    brk <= 1'b1;
    pulses(8'h04);
    rd(OFF_CNT_LO, d);
    chk(d, 8'(n));
    brk <= 1'b0;
    $display("test ext_clock done");
    wr(OFF_IRQ_MSK, 8'h02);
    wr(OFF_VAL0_LO, 8'h05);
    for (int i = 0; i < 6; i++)
    begin
      ma = (i < 3);
      code = 2'(i % 3 + 1);
      cfg = {2'b00, ~ma, ma | (i == 4), code, 2'b00};
      wr(OFF_SC, 8'h30);
      wr(OFF_CC0, {3'b000, ma, 4'h0});
      wr(OFF_CC0, cfg);
      repeat (3) @(posedge clock_i);
      chk({ch_oe[0], ch_do[0]}, {1'b1, ~ma});
      fire();
      chk(ch_do[0], out_lvl(~ma, code));
      chk(irq, 1'b1);
      rd(OFF_IRQ_ST, d);
      chk(d, 8'h02);
      rd(OFF_CC0, d);
      chk(d, cfg | 8'h80);
      wr(OFF_CC0, cfg);
      repeat (2) @(posedge clock_i);
      chk(irq, 1'b0);
    end
    $display("test compare done");
    fire();
    rd(OFF_CC0, d);
    brk <= 1'b1;
    rd(OFF_IRQ_ST, d);
    chk(d, 8'h02);
    wr(OFF_CC0, cfg);
    rd(OFF_CC0, d);
    chk(d[7], 1'b1);
    brk <= 1'b0;
    wr(OFF_CC0, cfg);
    rd(OFF_CC0, d);
    chk(d[7], 1'b0);
    rd(OFF_IRQ_ST, d);
    chk(d, 8'h02);
    fire();
    rd(OFF_CC0, d);
    wr(OFF_BREAK_FLAG_CONTROL_REG, 8'h80);
    brk <= 1'b1;
    wr(OFF_CC0, cfg);
    rd(OFF_IRQ_ST, d);
    chk(d, 8'h02);
    brk <= 1'b0;
    rd(OFF_CC0, d);
    chk(d[7], 1'b0);
    rd(OFF_IRQ_ST, d);
    chk(d, 8'h00);
    wr(OFF_BREAK_FLAG_CONTROL_REG, 8'h00);
    $display("test break done");
    for (int c = 1; c < 4; c++)
    begin
      cfg = {4'h0, 2'(c), 2'b00};
      wr(OFF_CC1, cfg);
      for (int e = 1; e >= 0; e--)
      begin
        ch_lvl[1] <= e[0];
        repeat (8) @(posedge clock_i);
        rd(OFF_CC1, d);
        chk(d[7], cap_hit(2'(c), e[0]));
        chk({ch_oe[1], irq}, 2'b00);
        wr(OFF_CC1, cfg);
      end
    end
    $display("test capture done");
    wr(OFF_IRQ_MSK, 8'h01);
    wr(OFF_MOD_LO, 8'h03);
    wr(OFF_MOD_HI, 8'h00);
    n = 1 + ($random(seed) & 3);
    wr(OFF_SC, 8'(8'h10 | n));
    repeat (50) @(posedge clock_i);
    wr(OFF_SC, 8'(8'h20 | n));
    rd(OFF_CNT_LO, d);
    chk(d, 8'(ticks(52, n) % 4));
    rd(OFF_SC, d);
    chk(d, {ticks(52, n) > 3, 7'(8'h20 | n)});
    chk(irq, ticks(52, n) > 3);
    $display("test prescaler done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
